// ---- hw/isrd_regs.sv ----
/*
  interrupt event flags and remote dma address/count registers.
  assumes a same-clock host bus with one-cycle rd/wr strobes and
  event pulses from the mac engines on the same clock.
*/
// What this block does
// [R1] bit 7 is set on reset or wake-up and cleared only by a start command.
// [R2] host writes to bit 7 change nothing.
// [R3] bit 6 is set when remote dma finishes; writing one clears it.
// [R4] bit 5 is set when a tally counter msb sets; writing one clears it.
// [R5] bit 4 is set when the receive ring is full; writing one clears it.
// [R6] bit 3 is set on a transmit error; writing one clears it.
// [R7] bit 2 is set on a receive error or missed frame; one clears it.
// [R8] bit 1 is set on a good transmit; writing one clears it.
// [R9] bit 0 is set on a good receive; writing one clears it.
// [R10] after reset the flags read 80h.
// [R11] the host programs start address and count, the dma uses them.
// [R12] offsets 08h and 09h write the low and high start address.
// [R13] offsets 0ah and 0bh write the low and high byte count.
// [R14] reads of 08h and 09h return the live dma address, reset zero.
// [R15] reading a tally counter clears it, removing its overflow.
// [R16] each dma access advances the address, counts down, done at zero.
`include "isrd_map.svh"

module isrd_regs
  import isrd_pkg::*;
(
  // clock and reset
  input  wire logic        clk,
  input  wire logic        rst_b,
  input  wire logic        ce,
  // host bus
  input  wire isrd_bus_t   host,
  output logic [7:0]       host_rdata,
  // events
  input  wire isrd_evt_t   evt,
  input  wire logic [1:0]  tally_msb,
  output logic [1:0]       tally_clr,
  output logic [7:0]       event_flags,
  // remote dma engine
  input  wire logic        dma_go,
  input  wire logic        dma_step,
  input  wire logic        dma_wide,
  output logic [15:0]      dma_addr,
  output logic [15:0]      dma_remain,
  output logic             dma_busy
);

  // ----------------------------------------
  // helpers
  // ----------------------------------------
  function automatic logic [15:0] put_byte(input logic [15:0] w,
                                           input logic        hi,
                                           input logic [7:0]  b);
    put_byte = hi ? {b, w[7:0]} : {w[15:8], b};
  endfunction : put_byte

  localparam isrd_state_t RST_ST = '{
    flags: `ISRD_FLAGS_RST, start_addr: `ISRD_WORD_RST,
    byte_cnt: `ISRD_WORD_RST, cur_addr: `ISRD_WORD_RST,
    remain: `ISRD_WORD_RST, st: ISRD_IDLE, msb_q: 2'h0,
    tally_clr: 2'h0, rdata: 8'h00};

  isrd_state_t s_ff;
  isrd_state_t nxt_s;
  logic        wr;
  logic        rd;
  logic        done;
  logic [15:0] step;

  assign wr   = host.cs & host.wr;
  assign rd   = host.cs & host.rd;
  assign step = dma_wide ? `ISRD_STEP_WORD : `ISRD_STEP_BYTE;

  // ----------------------------------------
  // next state
  // ----------------------------------------
  always_comb begin
    nxt_s = s_ff;
    done  = 1'b0;
    nxt_s.tally_clr = 2'h0;
    nxt_s.msb_q = tally_msb;
    if (rd) begin
      unique case (host.addr)
        `ISRD_OFS_FLAGS:   nxt_s.rdata = s_ff.flags;
        `ISRD_OFS_ADDR_LO: nxt_s.rdata = s_ff.cur_addr[7:0];  // R14
        `ISRD_OFS_ADDR_HI: nxt_s.rdata = s_ff.cur_addr[15:8]; // R14
        default:           nxt_s.rdata = 8'h00;
      endcase
      // counters live elsewhere; this only fires their read-clear
      nxt_s.tally_clr[0] = host.addr == `ISRD_OFS_TALLY0; // R15
      nxt_s.tally_clr[1] = host.addr == `ISRD_OFS_TALLY1; // R15
    end
    if (wr) begin
      unique case (host.addr)
        `ISRD_OFS_FLAGS:
          // bit 7 is not writable
          nxt_s.flags[6:0] = s_ff.flags[6:0] & ~host.wdata[6:0]; // R2
        `ISRD_OFS_ADDR_LO: nxt_s.start_addr =
            put_byte(s_ff.start_addr, 1'b0, host.wdata); // R12
        `ISRD_OFS_ADDR_HI: nxt_s.start_addr =
            put_byte(s_ff.start_addr, 1'b1, host.wdata); // R12
        `ISRD_OFS_CNT_LO: nxt_s.byte_cnt =
            put_byte(s_ff.byte_cnt, 1'b0, host.wdata); // R13
        `ISRD_OFS_CNT_HI: nxt_s.byte_cnt =
            put_byte(s_ff.byte_cnt, 1'b1, host.wdata); // R13
        default: ;
      endcase
    end
    // remote dma walk
    unique case (s_ff.st)
      ISRD_IDLE: begin
        if (dma_go) begin
          nxt_s.cur_addr = s_ff.start_addr; // R11
          nxt_s.remain   = s_ff.byte_cnt;   // R11
          if (s_ff.byte_cnt == 16'h0000) begin
            done = 1'b1;
          end else begin
            nxt_s.st = ISRD_RUN;
          end
        end
      end
      ISRD_RUN: begin
        if (dma_step) begin
          nxt_s.cur_addr = 16'(s_ff.cur_addr + step); // R16
          if (s_ff.remain <= step) begin
            // an odd tail on a word access still ends the block
            nxt_s.remain = 16'h0000; // R16
            nxt_s.st     = ISRD_IDLE;
            done         = 1'b1;
          end else begin
            nxt_s.remain = 16'(s_ff.remain - step); // R16
          end
        end
      end
    endcase
    // sets come last so an event beats a same-cycle clear
    if (evt.start_cmd) nxt_s.flags[`ISRD_BIT_RST] = 1'b0; // R1
    if (evt.rst_evt)   nxt_s.flags[`ISRD_BIT_RST] = 1'b1; // R1
    if (done)          nxt_s.flags[`ISRD_BIT_RDC] = 1'b1; // R3
    if (|(tally_msb & ~s_ff.msb_q))
      nxt_s.flags[`ISRD_BIT_CNT] = 1'b1; // R4
    if (evt.ring_overwrite_flag) nxt_s.flags[`ISRD_BIT_OVW] = 1'b1; // R5
    if (evt.send_error_flag) nxt_s.flags[`ISRD_BIT_TXE] = 1'b1; // R6
    if (evt.receive_error_flag) nxt_s.flags[`ISRD_BIT_RXE] = 1'b1; // R7
    if (evt.send_ok_flag) nxt_s.flags[`ISRD_BIT_PTX] = 1'b1; // R8
    if (evt.receive_ok_flag) nxt_s.flags[`ISRD_BIT_PRX] = 1'b1; // R9
  end

  always_ff @(posedge clk) begin
    if (!rst_b) begin
      s_ff <= RST_ST; // R10
    end else if (ce) begin
      s_ff <= nxt_s;
    end
  end

  assign host_rdata  = s_ff.rdata;
  assign event_flags = s_ff.flags;
  assign tally_clr   = s_ff.tally_clr;
  assign dma_addr    = s_ff.cur_addr;
  assign dma_remain  = s_ff.remain;
  assign dma_busy    = s_ff.st == ISRD_RUN;

  // ----------------------------------------
  // assertions
  // ----------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (!rst_b);

  logic fwr;
  assign fwr = ce && wr && host.addr == `ISRD_OFS_FLAGS;

  sequence last_step;
    ce && dma_busy && dma_step && s_ff.remain <= step;
  endsequence

  rst_set_a: assert property ( // R1
    ce && evt.rst_evt |=> event_flags[7])
    else $error("reset flag not set");
  rst_clr_a: assert property ( // R1
    ce && evt.start_cmd && !evt.rst_evt |=> !event_flags[7])
    else $error("reset flag not cleared by start");
  rst_wr_a: assert property ( // R2
    fwr && !evt.start_cmd && !evt.rst_evt |=> $stable(event_flags[7]))
    else $error("write changed reset flag");
  rdc_clr_a: assert property ( // R3
    fwr && host.wdata[6] && !done |=> !event_flags[6])
    else $error("done flag not cleared");
  rdc_keep_a: assert property ( // R3
    fwr && !host.wdata[6] && event_flags[6] |=> event_flags[6])
    else $error("zero write cleared done flag");
  cnt_set_a: assert property ( // R4
    ce && |(tally_msb & ~s_ff.msb_q) |=> event_flags[5])
    else $error("overflow flag missed");
  ovw_set_a: assert property ( // R5
    ce && evt.ring_overwrite_flag |=> event_flags[4]) else $error("overwrite missed");
  txe_set_a: assert property ( // R6
    ce && evt.send_error_flag |=> event_flags[3]) else $error("tx error missed");
  rxe_set_a: assert property ( // R7
    ce && evt.receive_error_flag |=> event_flags[2]) else $error("rx error missed");
  ptx_set_a: assert property ( // R8
    ce && evt.send_ok_flag |=> event_flags[1]) else $error("tx ok missed");
  prx_set_a: assert property ( // R9
    ce && evt.receive_ok_flag |=> event_flags[0]) else $error("rx ok missed");
  rst_val_a: assert property ( // R10
    $past(!rst_b) |-> event_flags == `ISRD_FLAGS_RST)
    else $error("flags wrong after reset");
  dma_load_a: assert property ( // R11
    ce && dma_go && !dma_busy |=> dma_addr == $past(s_ff.start_addr))
    else $error("dma did not load start address");
  sa_wr_a: assert property ( // R12
    ce && wr && host.addr == `ISRD_OFS_ADDR_HI
    |=> s_ff.start_addr[15:8] == $past(host.wdata))
    else $error("start address high not written");
  bc_wr_a: assert property ( // R13
    ce && wr && host.addr == `ISRD_OFS_CNT_LO
    |=> s_ff.byte_cnt[7:0] == $past(host.wdata))
    else $error("byte count low not written");
  cur_rd_a: assert property ( // R14
    ce && rd && host.addr == `ISRD_OFS_ADDR_LO
    |=> host_rdata == $past(dma_addr[7:0]))
    else $error("current address read wrong");
  tally_rd_a: assert property ( // R15
    ce && rd && host.addr == `ISRD_OFS_TALLY1 |=> tally_clr == 2'h2)
    else $error("tally clear pulse missing");
  dma_end_a: assert property ( // R16
    last_step |=> !dma_busy && event_flags[6] && dma_remain == 16'h0000)
    else $error("dma did not finish");

  // ----------------------------------------
  // write-one clears and zero writes
  // ----------------------------------------
  // each clear is checked only when no set of the same bit races it,
  // since the set is meant to win that cycle
  cnt_clr_a: assert property ( // R4
    fwr && host.wdata[5] && !(|(tally_msb & ~s_ff.msb_q))
    |=> !event_flags[5])
    else $error("overflow flag not cleared");
  ovw_clr_a: assert property ( // R5
    fwr && host.wdata[4] && !evt.ring_overwrite_flag |=> !event_flags[4])
    else $error("overwrite flag not cleared");
  txe_clr_a: assert property ( // R6
    fwr && host.wdata[3] && !evt.send_error_flag |=> !event_flags[3])
    else $error("tx error flag not cleared");
  rxe_clr_a: assert property ( // R7
    fwr && host.wdata[2] && !evt.receive_error_flag |=> !event_flags[2])
    else $error("rx error flag not cleared");
  ptx_clr_a: assert property ( // R8
    fwr && host.wdata[1] && !evt.send_ok_flag |=> !event_flags[1])
    else $error("tx ok flag not cleared");
  prx_clr_a: assert property ( // R9
    fwr && host.wdata[0] && !evt.receive_ok_flag |=> !event_flags[0])
    else $error("rx ok flag not cleared");
  cnt_keep_a: assert property ( // R4
    fwr && !host.wdata[5] && event_flags[5] |=> event_flags[5])
    else $error("zero write cleared overflow flag");
  ovw_keep_a: assert property ( // R5
    fwr && !host.wdata[4] && event_flags[4] |=> event_flags[4])
    else $error("zero write cleared overwrite flag");
  txe_keep_a: assert property ( // R6
    fwr && !host.wdata[3] && event_flags[3] |=> event_flags[3])
    else $error("zero write cleared tx error flag");
  rxe_keep_a: assert property ( // R7
    fwr && !host.wdata[2] && event_flags[2] |=> event_flags[2])
    else $error("zero write cleared rx error flag");
  ptx_keep_a: assert property ( // R8
    fwr && !host.wdata[1] && event_flags[1] |=> event_flags[1])
    else $error("zero write cleared tx ok flag");
  prx_keep_a: assert property ( // R9
    fwr && !host.wdata[0] && event_flags[0] |=> event_flags[0])
    else $error("zero write cleared rx ok flag");
  rst_hold_a: assert property ( // R1
    event_flags[7] && !(ce && evt.start_cmd) |=> event_flags[7])
    else $error("reset flag dropped without start");

  // ----------------------------------------
  // register writes and reads
  // ----------------------------------------
  sa_lo_a: assert property ( // R12
    ce && wr && host.addr == `ISRD_OFS_ADDR_LO
    |=> s_ff.start_addr[7:0] == $past(host.wdata))
    else $error("start address low not written");
  bc_hi_a: assert property ( // R13
    ce && wr && host.addr == `ISRD_OFS_CNT_HI
    |=> s_ff.byte_cnt[15:8] == $past(host.wdata))
    else $error("byte count high not written");
  cur_hi_a: assert property ( // R14
    ce && rd && host.addr == `ISRD_OFS_ADDR_HI
    |=> host_rdata == $past(dma_addr[15:8]))
    else $error("current address high read wrong");
  rd_hold_a: assert property ( // R14
    !(ce && rd) |=> $stable(host_rdata))
    else $error("read data moved without a read");
  tally0_rd_a: assert property ( // R15
    ce && rd && host.addr == `ISRD_OFS_TALLY0
    |=> tally_clr == 2'h1 && host_rdata == 8'h00)
    else $error("tally 0 read wrong");
  tclr_one_a: assert property ( // R15
    ce && !rd && tally_clr != 2'h0 |=> tally_clr == 2'h0)
    else $error("tally clear pulse too long");

  // ----------------------------------------
  // remote dma walk
  // ----------------------------------------
  sequence go_load;
    ce && dma_go && !dma_busy;
  endsequence

  sequence mid_step;
    ce && dma_busy && dma_step && s_ff.remain > step;
  endsequence

  sequence idle_step;
    ce && !dma_busy && !dma_go && dma_step;
  endsequence

  go_run_a: assert property ( // R11
    go_load ##0 s_ff.byte_cnt != 16'h0000
    |=> dma_busy && dma_remain == $past(s_ff.byte_cnt))
    else $error("dma did not load byte count");
  go_zero_a: assert property ( // R3
    go_load ##0 s_ff.byte_cnt == 16'h0000 |=> !dma_busy && event_flags[6])
    else $error("empty transfer not flagged");
  step_addr_a: assert property ( // R16
    mid_step
    |=> dma_addr == 16'($past(dma_addr) + $past(step)))
    else $error("dma address did not advance");
  step_cnt_a: assert property ( // R16
    mid_step
    |=> dma_busy && dma_remain == 16'($past(dma_remain) - $past(step)))
    else $error("dma count did not go down");
  idle_step_a: assert property ( // R16
    idle_step |=> $stable(dma_addr) && !dma_busy)
    else $error("step moved an idle dma");
  busy_go_a: assert property ( // R11
    ce && dma_busy && dma_go && !dma_step
    |=> $stable(dma_addr) && $stable(dma_remain))
    else $error("go restarted a running dma");

  // ----------------------------------------
  // clock enable
  // ----------------------------------------
  // a low enable must freeze every flag, pointer and pulse alike
  ce_hold_a: assert property (
    !ce |=> $stable(s_ff))
    else $error("state moved while disabled");

endmodule : isrd_regs

// ---- hw/isrd_map.svh ----
/*
  offsets, bit positions and reset values of the interrupt status
  and remote dma register slice.
  assumes a 4-bit page offset on the byte-wide host bus.
*/
`ifndef ISRD_MAP_SVH
`define ISRD_MAP_SVH

// ----------------------------------------
// offsets
// ----------------------------------------
`define ISRD_OFS_FLAGS   4'h7
`define ISRD_OFS_ADDR_LO 4'h8
`define ISRD_OFS_ADDR_HI 4'h9
`define ISRD_OFS_CNT_LO  4'ha
`define ISRD_OFS_CNT_HI  4'hb
`define ISRD_OFS_TALLY0  4'hd
`define ISRD_OFS_TALLY1  4'he

// ----------------------------------------
// flag bits
// ----------------------------------------
`define ISRD_BIT_RST  7
`define ISRD_BIT_RDC  6
`define ISRD_BIT_CNT  5
`define ISRD_BIT_OVW  4
`define ISRD_BIT_TXE  3
`define ISRD_BIT_RXE  2
`define ISRD_BIT_PTX  1
`define ISRD_BIT_PRX  0

// ----------------------------------------
// reset values and steps
// ----------------------------------------
`define ISRD_FLAGS_RST 8'h80
`define ISRD_WORD_RST  16'h0000
`define ISRD_STEP_BYTE 16'h0001
`define ISRD_STEP_WORD 16'h0002

`endif

// ---- hw/isrd_pkg.sv ----
/*
  types of the interrupt status and remote dma register slice.
  assumes nothing of its surroundings.
*/
package isrd_pkg;

  typedef enum logic [0:0] {
    ISRD_IDLE = 1'b0,
    ISRD_RUN  = 1'b1
  } isrd_dma_st_t;

  typedef struct packed {
    logic       cs;
    logic       rd;
    logic       wr;
    logic [3:0] addr;
    logic [7:0] wdata;
  } isrd_bus_t;

  typedef struct packed {
    logic rst_evt;
    logic start_cmd;
    logic ring_overwrite_flag;
    logic send_error_flag;
    logic receive_error_flag;
    logic send_ok_flag;
    logic receive_ok_flag;
  } isrd_evt_t;

  typedef struct packed {
    logic [7:0]   flags;
    logic [15:0]  start_addr;
    logic [15:0]  byte_cnt;
    logic [15:0]  cur_addr;
    logic [15:0]  remain;
    isrd_dma_st_t st;
    logic [1:0]   msb_q;
    logic [1:0]   tally_clr;
    logic [7:0]   rdata;
  } isrd_state_t;

endpackage : isrd_pkg

// ---- verif/isrd_host.sv ----
/*
  host microcontroller model driving the byte-wide register bus.
  assumes one-cycle strobes sampled on the rising clk edge.
*/
module isrd_host
  import isrd_pkg::*;
(
  // clock
  input  wire logic       clk,
  // host bus
  output isrd_bus_t       host,
  input  wire logic [7:0] host_rdata
);
  timeunit 1ns;
  timeprecision 1ps;

  initial host = '0;

  // strobe for one cycle, then release so no access is repeated
  task automatic wr(input logic [3:0] a, input logic [7:0] v);
    @(posedge clk) host <= '{1'b1, 1'b0, 1'b1, a, v};
    @(posedge clk) host <= '0;
    #1;
  endtask : wr

  task automatic rd(input logic [3:0] a, output logic [7:0] v);
    @(posedge clk) host <= '{1'b1, 1'b1, 1'b0, a, 8'h00};
    @(posedge clk) host <= '0;
    #1 v = host_rdata;
  endtask : rd
endmodule : isrd_host

// ---- verif/isrd_regs_tb.sv ----
/*
  self-checking bench of the event flag and remote dma slice.
  assumes the host model in isrd_host and a 40 mhz clock.
*/
module isrd_regs_tb
  import isrd_pkg::*;
();
  timeunit 1ns;
  timeprecision 1ps;

  logic        clk = 1'b0;
  logic        rst_b = 1'b0;
  logic        ce = 1'b1;
  isrd_bus_t   host;
  logic [7:0]  host_rdata, event_flags, d;
  isrd_evt_t   evt = '0;
  logic [1:0]  tally_msb = 2'h0, tally_clr;
  logic        dma_go = 1'b0, dma_step = 1'b0, dma_wide = 1'b0;
  logic        dma_busy;
  logic [15:0] dma_addr, dma_remain;
  int          failures = 0, n_checks = 0, cyc = 0;

  always #12.5 clk = ~clk;

  isrd_regs i_isrd_regs (.clk(clk), .rst_b(rst_b), .ce(ce),
    .host(host), .host_rdata(host_rdata), .evt(evt),
    .tally_msb(tally_msb), .tally_clr(tally_clr),
    .event_flags(event_flags), .dma_go(dma_go), .dma_step(dma_step),
    .dma_wide(dma_wide), .dma_addr(dma_addr), .dma_remain(dma_remain),
    .dma_busy(dma_busy));
  isrd_host i_isrd_host (.clk(clk), .host(host), .host_rdata(host_rdata));

  task automatic chk(input logic [15:0] g, e, input string m);
    n_checks++;
    if (g !== e) begin
      failures++;
      $display("MISMATCH %0t: %s got %h exp %h", $time, m, g, e);
    end
  endtask : chk

  task automatic pulse(input isrd_evt_t v);
    @(posedge clk) evt <= v;
    @(posedge clk) evt <= '0;
    #1;
  endtask : pulse

  task automatic t_reset;
    chk(16'(event_flags), 16'h0080, "flags");
    chk(dma_addr, 16'h0000, "addr");
    i_isrd_host.rd(4'h9, d);
    chk(16'(d), 16'h0000, "rd 09");
    $display("t_reset done");
  endtask : t_reset

  task automatic t_flags;
    for (int i = 0; i < 5; i++) begin
      pulse(isrd_evt_t'(7'h01 << i));
      chk(16'(event_flags), 16'h0080 | (16'h1 << i), "set");
      i_isrd_host.wr(4'h7, 8'h80);
      chk(16'(event_flags), 16'h0080 | (16'h1 << i), "keep");
      i_isrd_host.wr(4'h7, 8'h01 << i);
      chk(16'(event_flags), 16'h0080, "clear");
    end
    @(posedge clk) tally_msb <= 2'h2;
    @(posedge clk);
    #1 chk(16'(event_flags), 16'h00a0, "tally");
    i_isrd_host.wr(4'h7, 8'h20);
    chk(16'(event_flags), 16'h0080, "tally clr");
    pulse('{0, 1, 0, 0, 0, 0, 0});
    chk(16'(event_flags), 16'h0000, "start");
    pulse('{1, 0, 0, 0, 0, 0, 0});
    chk(16'(event_flags), 16'h0080, "wake");
    $display("t_flags done");
  endtask : t_flags

  // start 12feh makes the address carry into the high byte
  task automatic t_dma;
    i_isrd_host.wr(4'h8, 8'hfe);
    i_isrd_host.wr(4'h9, 8'h12);
    i_isrd_host.wr(4'ha, 8'h02);
    i_isrd_host.wr(4'hb, 8'h00);
    @(posedge clk) dma_go <= 1'b1;
    @(posedge clk) dma_go <= 1'b0;
    #1 chk(dma_addr, 16'h12fe, "go addr");
    chk(dma_remain, 16'h0002, "go cnt");
    @(posedge clk) dma_step <= 1'b1;
    @(posedge clk);
    #1 chk(dma_remain, 16'h0001, "step1");
    @(posedge clk) dma_step <= 1'b0;
    #1 chk(dma_addr, 16'h1300, "step2");
    chk({15'h0, dma_busy}, 16'h0000, "busy");
    chk(16'(event_flags), 16'h00c0, "done");
    i_isrd_host.rd(4'h8, d);
    chk(16'(d), 16'h0000, "live lo");
    i_isrd_host.rd(4'h9, d);
    chk(16'(d), 16'h0013, "live hi");
    i_isrd_host.wr(4'h7, 8'h40);
    chk(16'(event_flags), 16'h0080, "rdc clr");
    i_isrd_host.rd(4'hd, d);
    chk(16'(tally_clr), 16'h0001, "tally rd");
    $display("t_dma done");
  endtask : t_dma

  // word steps over an odd count, a frozen enable, a zero count
  task automatic t_wide;
    i_isrd_host.wr(4'ha, 8'h03);
    @(posedge clk) begin
      dma_wide <= 1'b1;
      dma_go   <= 1'b1;
    end
    @(posedge clk) dma_go <= 1'b0;
    #1 chk(dma_remain, 16'h0003, "wide go");
    @(posedge clk) dma_step <= 1'b1;
    @(posedge clk) ce <= 1'b0;
    @(posedge clk);
    #1 chk(dma_remain, 16'h0001, "frozen");
    @(posedge clk) ce <= 1'b1;
    @(posedge clk) dma_step <= 1'b0;
    #1 chk(dma_addr, 16'h1302, "wide end");
    chk({15'h0, dma_busy}, 16'h0000, "wide busy");
    chk(16'(event_flags), 16'h00c0, "wide done");
    i_isrd_host.wr(4'h7, 8'h40);
    i_isrd_host.wr(4'ha, 8'h00);
    @(posedge clk) dma_go <= 1'b1;
    @(posedge clk) dma_go <= 1'b0;
    #1 chk(16'(event_flags), 16'h00c0, "zero cnt");
    chk({15'h0, dma_busy}, 16'h0000, "zero busy");
    @(posedge clk) rst_b <= 1'b0;
    @(posedge clk) rst_b <= 1'b1;
    #1 chk(16'(event_flags), 16'h0080, "rerst");
    chk(dma_addr, 16'h0000, "rerst addr");
    $display("t_wide done");
  endtask : t_wide

  task automatic end_sim;
    $display("checks %0d mismatches %0d", n_checks, failures);
    if (failures == 0 && n_checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask : end_sim

  // ample margin over the roughly 80 cycles the tests need
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc == 600) begin
      failures++;
      end_sim();
    end
  end

  initial begin
    repeat (2) @(posedge clk);
    rst_b <= 1'b1;
    #1;
    t_reset();
    t_flags();
    t_dma();
    t_wide();
    end_sim();
  end
endmodule : isrd_regs_tb
